/* isel_top.sv */
// interrupt source selector: apb registers, source routing and line priority
// Notes on behaviour
// - The block drives sixteen interrupt lines, line 0 being reset and most urgent.
// - Among pending lines the lowest number is offered to the core first.
// - Lines 0 to 3 have fixed sources; lines 4 to 15 are maskable and steerable.
// - Each of lines 4 to 15 takes its source from a five-bit field of a selector register.
// - The high selector sits at 0x019c0000 and the low selector at 0x019c0004.
// - After reset the selector fields hold the listed default codes.
// - Selector codes map to timers, memory interface, pins, dma, emulation, serial, pin 0.
// - Pin events 4 to 7 are edge triggered with per-pin polarity.
// - A pin event is raised only for an enabled pin set as an input.
// - The global enable, clear after reset, gates the offer to the core of the maskable lines 4 to 15 only; nmi is offered regardless.
// - Taking an interrupt copies the global enable into the saved enable, reset to zero.
`timescale 1ns/10ps
module isel_top #(
  parameter int PINS = 4,
  parameter int EMU_EVENTS = 3,
  parameter int SERIAL_EVENTS = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer0_event,
  input wire logic timer1_event,
  input wire logic memory_iface_event,
  input wire logic dma_completion_event,
  input wire logic host_to_core_event,
  input wire logic pin0_event,
  input wire logic [EMU_EVENTS-1:0] emu_event,
  input wire logic [SERIAL_EVENTS-1:0] serial_event,
  input wire logic nmi_event,
  input wire logic [PINS-1:0] external_irq_pin,
  output logic [isel_pkg::ISEL_LINES-1:0] irq_line,
  output logic irq_request,
  output logic [3:0] irq_number,
  input wire logic irq_taken,
  input wire logic irq_return,
  output logic global_irq_enable,
  output logic saved_irq_enable
);
  import isel_pkg::*;

  localparam int NMASK = ISEL_LINES - ISEL_FIRST_MASKABLE;

  logic [31:0] interrupt_select_high;
  logic [31:0] interrupt_select_low;
  logic [PINS-1:0] external_edge_polarity;
  logic [PINS-1:0] pin_direction_field;
  logic [PINS-1:0] pin_enable_field;
  logic [PINS-1:0] pin4_event;
  logic [ISEL_CODES-1:0] source_vec;
  logic [ISEL_LINES-1:0] pending;
  logic [ISEL_LINES-1:0] next_pending;
  logic [ISEL_LINES-1:0] line_set;
  logic [ISEL_LINES-1:0] line_clr;
  logic [ISEL_LINES-1:0] eligible;
  logic [3:0] next_number;
  logic next_valid;
  logic nmi_sync1;
  logic nmi_sync2;
  logic nmi_sync3;
  logic nmi_level;
  logic nmi_edge;
  logic setup_phase;
  logic access_done;
  logic wr_ctl;
  logic [31:0] next_rdata;
  logic next_err;

  // one edge detector per external pin
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    isel_pin_edge u_edge (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin_raw(external_irq_pin[p]),
      .rising_sel(external_edge_polarity[p]),
      .pin_on(pin_enable_field[p]),
      .pin_is_input(~pin_direction_field[p]),
      .edge_event(pin4_event[p])
    );
  end

  // nmi comes from a pin too: three flops, then a rising edge once stable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      nmi_sync1 <= 1'b0;
      nmi_sync2 <= 1'b0;
      nmi_sync3 <= 1'b0;
      nmi_level <= 1'b0;
    end else begin
      nmi_sync1 <= nmi_event;
      nmi_sync2 <= nmi_sync1;
      nmi_sync3 <= nmi_sync2;
      if (nmi_sync2 == nmi_sync3) begin
        nmi_level <= nmi_sync2;
      end
    end
  end
  assign nmi_edge = (nmi_sync2 == nmi_sync3) && nmi_sync2 && !nmi_level;

  // event vector indexed by selector code
  always_comb begin
    source_vec = '0;
    source_vec[ISEL_CODE_HOST] = host_to_core_event;
    source_vec[ISEL_CODE_TIMER0] = timer0_event;
    source_vec[ISEL_CODE_TIMER1] = timer1_event;
    source_vec[ISEL_CODE_MEMIF] = memory_iface_event;
    for (int i = 0; i < PINS; i++) begin
      source_vec[int'(ISEL_CODE_PIN4) + i] = pin4_event[i];
    end
    source_vec[ISEL_CODE_DMA] = dma_completion_event;
    for (int i = 0; i < EMU_EVENTS; i++) begin
      source_vec[int'(ISEL_CODE_EMU0) + i] = emu_event[i];
    end
    for (int i = 0; i < SERIAL_EVENTS; i++) begin
      source_vec[int'(ISEL_CODE_SERIAL0) + i] = serial_event[i];
    end
    source_vec[ISEL_CODE_PIN0] = pin0_event;
  end

  // route the selected source onto each maskable line
  always_comb begin
    logic [4:0] code;
    code = '0;
    line_set = '0;
    line_set[ISEL_LINE_NMI] = nmi_edge;
    for (int i = 0; i < NMASK; i++) begin
      if (i < ISEL_FIELDS) begin
        code = interrupt_select_low[ISEL_FIELD_LSB[i] +: ISEL_SEL_W];
      end else begin
        code = interrupt_select_high[ISEL_FIELD_LSB[i - ISEL_FIELDS] +: ISEL_SEL_W];
      end
      // codes past the last event leave the line silent
      if (int'(code) < ISEL_CODES) begin
        line_set[ISEL_FIRST_MASKABLE + i] = source_vec[code];
      end
    end
  end

  // eligible lines: nmi always, maskable only with the global enable
  always_comb begin
    eligible = '0;
    eligible[ISEL_LINE_NMI] = pending[ISEL_LINE_NMI];
    for (int i = ISEL_FIRST_MASKABLE; i < ISEL_LINES; i++) begin
      eligible[i] = pending[i] && global_irq_enable;
    end
  end

  // lowest number wins, so scan from the top down
  always_comb begin
    next_valid = 1'b0;
    next_number = '0;
    for (int i = ISEL_LINES - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        next_valid = 1'b1;
        next_number = 4'(i);
      end
    end
  end

  // the taken line is cleared; a new event in that cycle still sets it
  always_comb begin
    line_clr = '0;
    if (irq_taken && irq_request) begin
      line_clr[irq_number] = 1'b1;
    end
    next_pending = (pending & ~line_clr) | line_set;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  // line outputs: line 0 mirrors reset, reserved lines 2 and 3 stay low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_line <= 16'h0001;
    end else begin
      irq_line <= next_pending & ~16'h000d;
    end
  end

  // request to the core; the number is held while a request stands
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_request <= 1'b0;
      irq_number <= '0;
    end else if (irq_request && !irq_taken) begin
      // a later, more urgent arrival is not swapped in mid-handshake
      irq_request <= 1'b1;
    end else begin
      irq_request <= next_valid && !(irq_taken && irq_request);
      irq_number <= next_number;
    end
  end

  // apb phases; one registered answer per transfer
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_ctl = access_done && pwrite && (paddr == ISEL_ADDR_CONTROL);

  // global and saved enables; hardware take and return beat a bus write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      global_irq_enable <= 1'b0;
      saved_irq_enable <= 1'b0;
    end else if (irq_taken && irq_request) begin
      saved_irq_enable <= global_irq_enable;
      global_irq_enable <= 1'b0;
    end else if (irq_return) begin
      global_irq_enable <= saved_irq_enable;
    end else if (wr_ctl) begin
      global_irq_enable <= pwdata[ISEL_CTL_GIE];
      saved_irq_enable <= pwdata[ISEL_CTL_SAVED_IRQ_ENABLE];
    end
  end

  // selector registers, reserved bits never stored
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      interrupt_select_high <= ISEL_SELECT_HIGH_RST;
      interrupt_select_low <= ISEL_SELECT_LOW_RST;
    end else if (access_done && pwrite) begin
      if (paddr == ISEL_ADDR_SELECT_HIGH) begin
        interrupt_select_high <= pwdata & ISEL_SELECT_MASK;
      end
      if (paddr == ISEL_ADDR_SELECT_LOW) begin
        interrupt_select_low <= pwdata & ISEL_SELECT_MASK;
      end
    end
  end

  // pin configuration register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      external_edge_polarity <= ISEL_PIN_CONFIG_RST[ISEL_PIN_POL_LSB +: PINS];
      pin_direction_field <= ISEL_PIN_CONFIG_RST[ISEL_PIN_DIR_LSB +: PINS];
      pin_enable_field <= ISEL_PIN_CONFIG_RST[ISEL_PIN_EN_LSB +: PINS];
    end else if (access_done && pwrite && paddr == ISEL_ADDR_PIN_CONFIG) begin
      external_edge_polarity <= pwdata[ISEL_PIN_POL_LSB +: PINS];
      pin_direction_field <= pwdata[ISEL_PIN_DIR_LSB +: PINS];
      pin_enable_field <= pwdata[ISEL_PIN_EN_LSB +: PINS];
    end
  end

  // read mux; an unmapped address answers zero with an error
  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    unique case (paddr)
      ISEL_ADDR_SELECT_HIGH: next_rdata = interrupt_select_high;
      ISEL_ADDR_SELECT_LOW: next_rdata = interrupt_select_low;
      ISEL_ADDR_CONTROL: begin
        next_rdata[ISEL_CTL_GIE] = global_irq_enable;
        next_rdata[ISEL_CTL_SAVED_IRQ_ENABLE] = saved_irq_enable;
      end
      ISEL_ADDR_PIN_CONFIG: begin
        next_rdata[ISEL_PIN_POL_LSB +: PINS] = external_edge_polarity;
        next_rdata[ISEL_PIN_DIR_LSB +: PINS] = pin_direction_field;
        next_rdata[ISEL_PIN_EN_LSB +: PINS] = pin_enable_field;
      end
      ISEL_ADDR_STATUS: next_rdata[ISEL_LINES-1:0] = pending;
      default: next_err = 1'b1;
    endcase
  end

  // answer prepared in the setup cycle so outputs stay registered
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= next_err;
    end else begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
  end
endmodule : isel_top

/* isel_pkg.sv */
// constants shared by the interrupt source selector
package isel_pkg;
  // register byte addresses on the apb bus
  localparam logic [31:0] ISEL_ADDR_SELECT_HIGH = 32'h019c0000;
  localparam logic [31:0] ISEL_ADDR_SELECT_LOW = 32'h019c0004;
  localparam logic [31:0] ISEL_ADDR_CONTROL = 32'h019c0008;
  localparam logic [31:0] ISEL_ADDR_PIN_CONFIG = 32'h019c000c;
  localparam logic [31:0] ISEL_ADDR_STATUS = 32'h019c0010;

  // selector field layout, same in both selector registers
  localparam int ISEL_SEL_W = 5;
  localparam int ISEL_FIELDS = 6;
  localparam int ISEL_FIELD_LSB [ISEL_FIELDS] = '{0, 5, 10, 16, 21, 26};

  // selector reset values: low register for lines 4-9, high for lines 10-15
  localparam logic [31:0] ISEL_SELECT_LOW_RST = 32'h250718a4;
  localparam logic [31:0] ISEL_SELECT_HIGH_RST = 32'h08202d43;
  localparam logic [31:0] ISEL_SELECT_MASK = 32'h7fff7fff;

  // selector codes
  localparam logic [4:0] ISEL_CODE_HOST = 5'h00;
  localparam logic [4:0] ISEL_CODE_TIMER0 = 5'h01;
  localparam logic [4:0] ISEL_CODE_TIMER1 = 5'h02;
  localparam logic [4:0] ISEL_CODE_MEMIF = 5'h03;
  localparam logic [4:0] ISEL_CODE_PIN4 = 5'h04;
  localparam logic [4:0] ISEL_CODE_DMA = 5'h08;
  localparam logic [4:0] ISEL_CODE_EMU0 = 5'h09;
  localparam logic [4:0] ISEL_CODE_SERIAL0 = 5'h0c;
  localparam logic [4:0] ISEL_CODE_PIN0 = 5'h10;
  localparam int ISEL_CODES = 17;

  // control register fields
  localparam int ISEL_CTL_GIE = 0;
  localparam int ISEL_CTL_SAVED_IRQ_ENABLE = 1;
  // pin config fields: polarity 3:0, direction 7:4, enable 15:12
  localparam int ISEL_PIN_POL_LSB = 0;
  localparam int ISEL_PIN_DIR_LSB = 4;
  localparam int ISEL_PIN_EN_LSB = 12;
  localparam logic [15:0] ISEL_PIN_CONFIG_RST = 16'h00f0;

  // line numbers
  localparam int ISEL_LINES = 16;
  localparam int ISEL_FIRST_MASKABLE = 4;
  localparam int ISEL_LINE_NMI = 1;
endpackage : isel_pkg

/* isel_pin_edge.sv */
// one external pin: three-flop synchroniser and qualified edge detect
`timescale 1ns/10ps
module isel_pin_edge (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pin_raw,
  input wire logic rising_sel,
  input wire logic pin_on,
  input wire logic pin_is_input,
  output logic edge_event
);
  logic sync1;
  logic sync2;
  logic sync3;
  logic level;

  // first flop feeds only the second, to contain metastability
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // accepted level moves only when the two later stages agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      level <= 1'b0;
    end else if (sync2 == sync3) begin
      level <= sync2;
    end
  end

  // pulse on the chosen edge, only for an enabled input pin
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      edge_event <= 1'b0;
    end else begin
      edge_event <= pin_on && pin_is_input && (sync2 == sync3) && (sync2 != level)
                    && (sync2 == rising_sel);
    end
  end
endmodule : isel_pin_edge

/* isel_props.sv */
// checker for the selector: bus answer, offer order and enable handling
`timescale 1ns/10ps
module isel_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [15:0] irq_line,
  input wire logic irq_request,
  input wire logic [3:0] irq_number,
  input wire logic irq_taken,
  input wire logic irq_return,
  input wire logic global_irq_enable,
  input wire logic saved_irq_enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // a maskable line is newly offered
  sequence masked_offer;
    $rose(irq_request) && irq_number >= 4'd4;
  endsequence
  reset_state_a: assert property ($fell(sys_rst) |-> irq_line == 16'h0001
    && !global_irq_enable && !saved_irq_enable) else $error("state after reset wrong");
  fixed_lines_a: assert property (irq_line[3:2] == 2'b00
    && (!irq_line[0] || $past(sys_rst))) else $error("fixed line driven");
  offer_order_a: assert property (masked_offer |->
    ($past(irq_line) & ((16'h1 << irq_number) - 16'h1) & 16'hfffe) == 16'h0)
    else $error("more urgent line skipped");
  gated_offer_a: assert property (masked_offer |-> $past(global_irq_enable))
    else $error("offer while disabled");
  offer_hold_a: assert property (irq_request && !irq_taken |=>
    irq_request && $stable(irq_number)) else $error("offer withdrawn");
  take_save_a: assert property (irq_request && irq_taken && !irq_return
    && irq_number >= 4'd4 |=> !irq_request && !global_irq_enable
    && saved_irq_enable == $past(global_irq_enable)) else $error("take did not save");
  return_restore_a: assert property (irq_return && !irq_taken |=>
    global_irq_enable == $past(saved_irq_enable)) else $error("return did not restore");
  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer late");
  cover property (masked_offer);
  cover property (irq_request && irq_taken);
  cover property (irq_return);
endmodule : isel_props
bind isel_top isel_props i_isel_props (.mclk, .sys_rst, .psel, .penable, .pready, .irq_line,
  .irq_request, .irq_number, .irq_taken, .irq_return, .global_irq_enable, .saved_irq_enable);

/* isel_core_model.sv */
// core side model: accepts offered lines, then returns from them
`timescale 1ns/10ps
module isel_core_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic irq_request,
  input wire logic [3:0] irq_number,
  input wire logic [1:0] delay,
  output logic irq_taken = 1'b0,
  output logic irq_return = 1'b0,
  output logic seen_valid = 1'b0,
  output logic [3:0] seen_number = 4'h0
);
  logic [1:0] wait_cnt;
  logic [2:0] ret_cnt;
  // take after a chosen delay; return later so the saved enable comes back
  always_ff @(posedge mclk) begin
    irq_taken <= 1'b0;
    irq_return <= 1'b0;
    seen_valid <= 1'b0;
    if (sys_rst) begin
      wait_cnt <= 2'h0;
      ret_cnt <= 3'h0;
    end else if (ret_cnt != 3'h0) begin
      ret_cnt <= ret_cnt - 3'h1;
      irq_return <= (ret_cnt == 3'h1);
    end else if (irq_request && !irq_taken) begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt == delay) begin
        irq_taken <= 1'b1;
        seen_valid <= 1'b1;
        seen_number <= irq_number;
        wait_cnt <= 2'h0;
        ret_cnt <= 3'h3;
      end
    end
  end
endmodule : isel_core_model

/* interrupt_source_selector_test.sv */
// self-checking bench for the interrupt source selector
`timescale 1ns/10ps
module interrupt_source_selector_test;
  import isel_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nmi_event = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, cfg;
  logic pready, pslverr, er, pol, irq_request, irq_taken, irq_return, seen_valid;
  logic timer0_event = 1'b0, timer1_event = 1'b0, memory_iface_event = 1'b0;
  logic dma_completion_event = 1'b0, host_to_core_event = 1'b0, pin0_event = 1'b0;
  logic [2:0] emu_event = 3'h0;
  logic [3:0] serial_event = 4'h0, external_irq_pin = 4'h0, irq_number, seen_number;
  logic [15:0] irq_line;
  logic global_irq_enable, saved_irq_enable;
  logic [1:0] core_delay = 2'h0;
  logic [15:0] rnd = 16'h004f;
  logic [3:0] got_q[$];
  int failures = 0;
  int total_checks = 0;
  int tgt;
  isel_top i_isel_top (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer0_event, .timer1_event, .memory_iface_event, .dma_completion_event,
    .host_to_core_event, .pin0_event, .emu_event, .serial_event, .nmi_event, .external_irq_pin,
    .irq_line, .irq_request, .irq_number, .irq_taken, .irq_return, .global_irq_enable,
    .saved_irq_enable);
  isel_core_model i_isel_core_model (.mclk, .sys_rst, .irq_request, .irq_number,
    .delay(core_delay), .irq_taken, .irq_return, .seen_valid, .seen_number);
  always #25 mclk = ~mclk;
  // record every line the core accepted, in order
  always @(posedge mclk) begin
    if (seen_valid === 1'b1) got_q.push_back(seen_number);
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // six codes packed into the selector field layout
  function automatic logic [31:0] sel_word(input logic [29:0] c);
    sel_word = 32'h0;
    for (int k = 0; k < ISEL_FIELDS; k++) sel_word[ISEL_FIELD_LSB[k] +: 5] = c[5*k +: 5];
  endfunction : sel_word
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic timeout(input string what);
    failures++;
    $display("BAD %s expected answer seen none", what);
    print_verdict();
  endtask : timeout
  task automatic roll();
    rnd = lfsr_next(rnd);
  endtask : roll
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout("bus");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // steer one line to a code, every other line to a silent code
  task automatic route(input int line, input logic [4:0] code);
    logic [29:0] hi, lo;
    hi = '1;
    lo = '1;
    if (line < 10) lo[5*(line-4) +: 5] = code;
    else hi[5*(line-10) +: 5] = code;
    apb(1'b1, ISEL_ADDR_SELECT_LOW, sel_word(lo));
    apb(1'b1, ISEL_ADDR_SELECT_HIGH, sel_word(hi));
  endtask : route
  // one-cycle pulse on the non-pin sources whose code bit is set; pin codes 4 to 7 drive nothing
  task automatic fire(input logic [16:0] m);
    @(posedge mclk);
    {pin0_event, serial_event, emu_event, dma_completion_event} <= m[16:8];
    {memory_iface_event, timer1_event, timer0_event, host_to_core_event} <= m[3:0];
    @(posedge mclk);
    {pin0_event, serial_event, emu_event, dma_completion_event} <= 9'h0;
    {memory_iface_event, timer1_event, timer0_event, host_to_core_event} <= 4'h0;
  endtask : fire
  task automatic wait_irq(input logic [3:0] exp);
    for (int n = 0; n < 80 && got_q.size() == 0; n++) @(posedge mclk);
    if (got_q.size() == 0) timeout("interrupt");
    check("line taken", 32'(exp), 32'(got_q.pop_front()));
    repeat (4) @(posedge mclk);
  endtask : wait_irq
  task automatic quiet(input string what);
    repeat (16) @(posedge mclk);
    check(what, 32'h0, 32'(got_q.size()));
  endtask : quiet
  initial begin
    repeat (5) @(posedge mclk);
    check("line 0 in reset", 32'h1, 32'(irq_line));
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    check("enables", 32'h0, {30'h0, saved_irq_enable, global_irq_enable});
    apb(1'b0, ISEL_ADDR_SELECT_LOW, 32'h0);
    check("select low", sel_word({5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04}), rd);
    apb(1'b0, ISEL_ADDR_SELECT_HIGH, 32'h0);
    check("select high", sel_word({5'h02, 5'h01, 5'h00, 5'h0b, 5'h0a, 5'h03}), rd);
    apb(1'b0, 32'h019c0020, 32'h0);
    check("unmapped error", 32'h1, 32'(er));
    roll();
    apb(1'b1, ISEL_ADDR_SELECT_LOW, {rnd, ~rnd});
    apb(1'b0, ISEL_ADDR_SELECT_LOW, 32'h0);
    check("select readback", {rnd, ~rnd} & ISEL_SELECT_MASK, rd);
    // put the default routing back so timer 0 reaches line 14 only
    apb(1'b1, ISEL_ADDR_SELECT_LOW, ISEL_SELECT_LOW_RST);
    // timer 0 waits while disabled; nmi is offered regardless
    fire(17'h2);
    quiet("gated line");
    apb(1'b0, ISEL_ADDR_STATUS, 32'h0);
    check("pending status", 32'h00004000, rd);
    check("line outputs", 32'h00004000, 32'(irq_line));
    nmi_event <= 1'b1;
    wait_irq(4'd1);
    nmi_event <= 1'b0;
    apb(1'b1, ISEL_ADDR_CONTROL, 32'h1);
    wait_irq(4'd14);
    core_delay <= 2'h3;
    fire(17'he);
    wait_irq(4'd10);
    wait_irq(4'd14);
    wait_irq(4'd15);
    // every code on a random line; pins need enable, input and the chosen edge
    for (int c = 0; c < ISEL_CODES; c++) begin
      roll();
      tgt = 4 + int'(rnd % 16'd12);
      core_delay <= rnd[5:4];
      route(tgt, 5'(c));
      if (c >= 4 && c <= 7) begin
        pol = rnd[0];
        cfg = 32'h0000f0f0 | (32'(pol) << (c - 4));
        apb(1'b1, ISEL_ADDR_PIN_CONFIG, cfg);
        apb(1'b0, ISEL_ADDR_PIN_CONFIG, 32'h0);
        check("pin config", cfg, rd);
        external_irq_pin[c-4] <= !pol;
        repeat (8) @(posedge mclk);
        external_irq_pin[c-4] <= pol;
        quiet("output pin");
        apb(1'b1, ISEL_ADDR_PIN_CONFIG, cfg & 32'hffffff0f);
        external_irq_pin[c-4] <= !pol;
        quiet("inactive edge");
        external_irq_pin[c-4] <= pol;
      end else begin
        fire(17'h1 << c);
      end
      wait_irq(4'(tgt));
    end
    roll();
    route(4 + int'(rnd % 16'd12), 5'd17 + 5'(rnd[7:4] % 4'd15));
    fire(17'h1ffff);
    quiet("silent code");
    // last take saved an enabled state and the return restored it
    apb(1'b0, ISEL_ADDR_CONTROL, 32'h0);
    check("control readback", 32'h3, rd);
    check("global enable", 32'h1, 32'(global_irq_enable));
    print_verdict();
  end
endmodule : interrupt_source_selector_test
